/* dv/dpl_ref_model.sv */
// reference sources, selection causes and frame/clock pins facing one dpll channel
`timescale 1ns/1ns
module dpl_ref_model #(
  parameter int LOCK_CYC = 6
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [1:0] refUp,
  input  wire logic       lockEn,
  input  wire logic       revertReq,
  input  wire logic       forceReq,
  input  wire logic       frameGo,
  output logic            anyQual,
  output logic            selQual,
  output logic            lockDet,
  output logic            swDisq,
  output logic            swRevert,
  output logic            swForced,
  output logic            framePin,
  output logic            assocClkPin
);
  logic       sel_r;
  logic       go_r;
  logic [3:0] lockCnt_r;
  logic [5:0] phase_r;
  // ----------------------------------------
  // selection and lock detection
  // ----------------------------------------
  // reference 0 is the higher priority; a switch restarts the lock count
  always_ff @(posedge core_clk) begin
    swDisq <= 1'b0;
    swRevert <= 1'b0;
    swForced <= 1'b0;
    if (reset) begin
      sel_r <= 1'b0;
      go_r <= 1'b0;
      lockCnt_r <= '0;
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 6'h01;
      if (phase_r == 6'h00) begin
        go_r <= frameGo;
      end
      if (!refUp[sel_r] && refUp[!sel_r]) begin
        sel_r <= !sel_r;
        swDisq <= 1'b1;
        lockCnt_r <= '0;
      end else if (revertReq && sel_r && refUp[0]) begin
        sel_r <= 1'b0;
        swRevert <= 1'b1;
        lockCnt_r <= '0;
      end else if (forceReq && refUp[!sel_r]) begin
        sel_r <= !sel_r;
        swForced <= 1'b1;
        lockCnt_r <= '0;
      end else if (!lockEn || !refUp[sel_r]) begin
        lockCnt_r <= '0;
      end else if (lockCnt_r != 4'(LOCK_CYC)) begin
        lockCnt_r <= lockCnt_r + 4'h1;
      end
    end
  end
  // qualification is level; lock shows only after a steady stretch
  assign anyQual = |refUp;
  assign selQual = refUp[sel_r];
  assign lockDet = (lockCnt_r == 4'(LOCK_CYC));
  // clock period 16 cycles, far below the limits; frame every 4 clocks, edges on clock falls
  assign assocClkPin = ~phase_r[3];
  assign framePin = go_r && (phase_r[5:3] == 3'h1 || phase_r[5:3] == 3'h2);
endmodule // dpl_ref_model

/* dv/tb.sv */
// self-checking bench for the dpll state and alignment block
`timescale 1ns/1ns
`include "dpl_regs.svh"
module tb;
  import dpl_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0]  refUp = 2'b00;
  logic        lockEn = 0, revertReq = 0, forceReq = 0, frameGo = 0, ce = 1;
  logic        anyQual, selQual, lockDet, swDisq, swRevert, swForced, framePin, assocClkPin;
  dpl_off_t    freqOffset = 24'h001000;
  dpl_state_e  dpllState;
  logic        freeRun, trackEn, holdAct, intLoad, alignPulse;
  logic [3:0]  bwCode;
  dpl_off_t    intVal;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [16:0] bwNom [10] = '{17'd178, 17'd356, 17'd712, 17'd944, 17'd1420, 17'd2850,
                              17'd3330, 17'd5710, 17'd114000, 17'd121000};
  always #20 core_clk = ~core_clk;
  dpl_ref_model refs (.core_clk(core_clk), .reset(reset), .refUp(refUp), .lockEn(lockEn),
    .revertReq(revertReq), .forceReq(forceReq), .frameGo(frameGo), .anyQual(anyQual),
    .selQual(selQual), .lockDet(lockDet), .swDisq(swDisq), .swRevert(swRevert),
    .swForced(swForced), .framePin(framePin), .assocClkPin(assocClkPin));
  // short second so the holdover stores refresh every few cycles
  dpl_state_align #(.SEC_CYC(10)) uut (.core_clk(core_clk), .reset(reset), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .anyQual(anyQual),
    .selQual(selQual), .lockDet(lockDet), .swDisq(swDisq), .swRevert(swRevert),
    .swForced(swForced), .freqOffset(freqOffset), .framePin(framePin),
    .assocClkPin(assocClkPin), .dpllState(dpllState), .freeRun(freeRun), .trackEn(trackEn),
    .holdAct(holdAct), .bwCode(bwCode), .intLoad(intLoad), .intVal(intVal),
    .alignPulse(alignPulse));
  // ----------------------------------------
  // reporting and compare tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic give_up(input string nm);
    fail_count++;
    $display("CHECK FAILED %s expected an answer seen none", nm);
    report_and_stop();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // window compare; an unknown value never lands inside
  task automatic chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                        input logic [31:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  // address and data offered together, each released on the edge it is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1 || !(aw && w)) begin
      @(posedge core_clk);
      n++;
      if (n > 50) give_up("write answer");
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    @(posedge core_clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 50) give_up("read address");
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 100) give_up("read answer");
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    @(posedge core_clk);
  endtask
  // values are read as sampled at each rising edge
  task automatic wait_state(input dpl_state_e s);
    int n;
    n = 0;
    while (dpllState !== s && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk("dpllState", 32'(s), 32'(dpllState));
    if (dpllState !== s) report_and_stop();
  endtask
  task automatic pulse(input logic rev);
    if (rev) revertReq <= 1'b1;
    else forceReq <= 1'b1;
    @(posedge core_clk);
    revertReq <= 1'b0;
    forceReq <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    chk("state", 32'(FREERUN), 32'(dpllState));
    chk("freeRun", 32'h1, 32'(freeRun));
    axi_rd(`DPL_CTRL_OFS, `DPL_CTRL_RST, `DPL_RESP_OK);
    axi_rd(`DPL_BWREQ_OFS, 32'(`DPL_BWREQ_RST), `DPL_RESP_OK);
    axi_rd(`DPL_IVL_OFS, 32'(`DPL_IVL_RST), `DPL_RESP_OK);
    axi_rd(`DPL_STATUS_OFS, 32'h0000_0090, `DPL_RESP_OK);
    axi_wr(`DPL_STATUS_OFS, 32'hFFFF_FFFF, `DPL_RESP_OK);
    axi_rd(`DPL_STATUS_OFS, 32'h0000_0090, `DPL_RESP_OK);
    axi_wr(`DPL_IVL_OFS, 32'h0000_003F, `DPL_RESP_OK);
    axi_rd(`DPL_IVL_OFS, 32'h0000_003F, `DPL_RESP_OK);
    axi_wr(`DPL_IVL_OFS, 32'h0000_0001, `DPL_RESP_OK);
    axi_wr(8'h18, 32'h1234_5678, `DPL_RESP_ERR);
    axi_rd(8'h18, 32'h0000_0000, `DPL_RESP_ERR);
    $display("test regs finished");
  endtask
  // each nominal value and the request just below it
  task automatic t_bw;
    int n;
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 2; k++) begin
        axi_wr(`DPL_BWREQ_OFS, 32'(bwNom[i] - 17'(k)), `DPL_RESP_OK);
        n = 0;
        while (bwCode !== 4'((i > 0) ? i - k : 0) && n < 8) begin
          @(posedge core_clk);
          n++;
        end
        chk("bwCode", 32'((i > 0) ? i - k : 0), 32'(bwCode));
        if (bwCode !== 4'((i > 0) ? i - k : 0)) report_and_stop();
      end
    end
    $display("test bw finished");
  endtask
  task automatic t_auto;
    refUp <= 2'b01;
    wait_state(LOCK_ACQ);
    refUp <= 2'b10;
    repeat (8) @(posedge core_clk);
    chk("state", 32'(LOCK_ACQ), 32'(dpllState));
    refUp <= 2'b00;
    wait_state(FREERUN);
    // with the clock enable low the machine must not move
    ce <= 1'b0;
    refUp <= 2'b01;
    lockEn <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk("frozen", 32'(FREERUN), 32'(dpllState));
    ce <= 1'b1;
    wait_state(LOCKED);
    chk("trackEn", 32'h1, 32'(trackEn));
    chk("freeRun", 32'h0, 32'(freeRun));
    lockEn <= 1'b0;
    refUp <= 2'b11;
    @(posedge core_clk);
    pulse(1'b0);
    wait_state(LOCK_REC);
    pulse(1'b1);
    repeat (8) @(posedge core_clk);
    chk("state", 32'(LOCK_REC), 32'(dpllState));
    lockEn <= 1'b1;
    wait_state(LOCKED);
    refUp <= 2'b00;
    wait_state(HOLDOVER);
    chk("intLoad", 32'h1, 32'(intLoad));
    chk("intVal", 32'h0000_1000, 32'(intVal));
    chk("holdAct", 32'h1, 32'(holdAct));
    lockEn <= 1'b0;
    refUp <= 2'b01;
    wait_state(LOCK_REC);
    refUp <= 2'b00;
    wait_state(HOLDOVER);
    $display("test auto finished");
  endtask
  // late offset change must not reach the older store
  task automatic t_adv;
    axi_wr(`DPL_CTRL_OFS, 32'h0000_0008, `DPL_RESP_OK);
    refUp <= 2'b01;
    lockEn <= 1'b1;
    wait_state(LOCKED);
    repeat (300) @(posedge core_clk);
    freqOffset <= 24'h002000;
    repeat (2) @(posedge core_clk);
    refUp <= 2'b00;
    wait_state(HOLDOVER);
    chk("intLoad", 32'h1, 32'(intLoad));
    chk_in("intVal", 32'h0000_0FF1, 32'h0000_1000, 32'(intVal));
    $display("test adv finished");
  endtask
  task automatic t_modes;
    refUp <= 2'b01;
    lockEn <= 1'b1;
    axi_wr(`DPL_MANHOLD_OFS, 32'h00AB_CDEF, `DPL_RESP_OK);
    axi_wr(`DPL_CTRL_OFS, 32'(`DPL_MODE_FLOCK), `DPL_RESP_OK);
    wait_state(LOCKED);
    axi_wr(`DPL_CTRL_OFS, 32'(`DPL_MODE_FFREE), `DPL_RESP_OK);
    wait_state(FREERUN);
    chk("freeRun", 32'h1, 32'(freeRun));
    axi_wr(`DPL_CTRL_OFS, 32'(`DPL_MODE_FHOLD), `DPL_RESP_OK);
    wait_state(HOLDOVER);
    repeat (20) @(posedge core_clk);
    chk("state", 32'(HOLDOVER), 32'(dpllState));
    axi_wr(`DPL_CTRL_OFS, 32'(`DPL_MODE_FFREE), `DPL_RESP_OK);
    wait_state(FREERUN);
    axi_wr(`DPL_CTRL_OFS, 32'(`DPL_MODE_MHOLD), `DPL_RESP_OK);
    wait_state(HOLDOVER);
    chk("intVal", 32'h00AB_CDEF, 32'(intVal));
    $display("test modes finished");
  endtask
  // cycles from the chosen pin edge to the alignment pulse
  task automatic t_align(input logic fall, input logic sync, input logic [31:0] lo,
                         input logic [31:0] hi);
    int n;
    logic prev;
    axi_wr(`DPL_CTRL_OFS, {25'h0, 1'b1, sync, fall, 4'h0}, `DPL_RESP_OK);
    frameGo <= 1'b1;
    prev = framePin;
    n = 0;
    while (!(prev === fall && framePin === !fall)) begin
      prev = framePin;
      @(posedge core_clk);
      n++;
      if (n > 200) give_up("frame edge");
    end
    n = 0;
    while (alignPulse !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > 40) give_up("alignPulse");
    end
    chk_in("alignDelay", lo, hi, 32'(n));
    frameGo <= 1'b0;
    repeat (70) @(posedge core_clk);
    $display("test align finished");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_bw();
    t_auto();
    t_adv();
    t_modes();
    for (int f = 0; f < 2; f++) begin
      t_align(f[0], 1'b0, 32'd10, 32'd15);
      t_align(f[0], 1'b1, 32'd2, 32'd7);
    end
    report_and_stop();
  end
endmodule // tb

/* hdl/dpl_pkg.sv */
// types and the bandwidth quantiser of the dpll state and alignment block
package dpl_pkg;
  typedef enum logic [2:0] {
    FREERUN, LOCK_ACQ, LOCKED, HOLDOVER, LOCK_REC
  } dpl_state_e;
  typedef logic [23:0] dpl_off_t;
  typedef struct packed {
    dpl_state_e  st;
    logic [7:0]  awa;
    logic        awHave;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        wHave;
    logic        awRdy;
    logic        wRdy;
    logic        bVal;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rVal;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [31:0] ctrl;
    logic [16:0] bwReq;
    logic [5:0]  ivl;
    dpl_off_t    manHold;
    logic [31:0] secCnt;
    logic [5:0]  ivlCnt;
    dpl_off_t    filt;
    dpl_off_t    hold0;
    dpl_off_t    hold1;
    dpl_off_t    lastOff;
    logic [3:0]  bwCode;
    logic        intLoad;
    dpl_off_t    intVal;
    logic        freeRun;
    logic        trackEn;
    logic        holdAct;
    logic [1:0]  frmSy;
    logic        frmPrev;
    logic [1:0]  clkSy;
    logic        clkPrev;
    logic        armed;
    logic        alignPulse;
  } dpl_state_s;
  // largest nominal bandwidth not above the request, code 0 below the second entry, in 0.1 Hz units
  function automatic logic [3:0] dpl_bw_quant(input logic [16:0] req);
    logic [16:0] tab [10];
    logic [3:0]  code;
    tab = '{17'h000B2, 17'h00164, 17'h002C8, 17'h003B0, 17'h0058C,
            17'h00B22, 17'h00D02, 17'h0164E, 17'h1BD50, 17'h1D8A8};
    code = 4'h0;
    for (int i = 1; i < 10; i++) begin
      if (req >= tab[i]) begin
        code = 4'(i);
      end
    end
    return code;
  endfunction
endpackage

/* hdl/dpl_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef DPL_REGS_SVH
`define DPL_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DPL_CTRL_OFS     8'h00
`define DPL_BWREQ_OFS    8'h04
`define DPL_IVL_OFS      8'h08
`define DPL_MANHOLD_OFS  8'h0C
`define DPL_STATUS_OFS   8'h10
`define DPL_HOLDVAL_OFS  8'h14
// ----------------------------------------
// control fields
// ----------------------------------------
`define DPL_CTRL_MODE    2:0
`define DPL_CTRL_ADV     3
`define DPL_CTRL_FALL    4
`define DPL_CTRL_SYNC    5
`define DPL_CTRL_ALIGN   6
// operating mode codes
`define DPL_MODE_AUTO    3'h0
`define DPL_MODE_FLOCK   3'h1
`define DPL_MODE_FFREE   3'h2
`define DPL_MODE_FHOLD   3'h3
`define DPL_MODE_MHOLD   3'h4
// reset values
`define DPL_CTRL_RST     32'h0000_0000
`define DPL_BWREQ_RST    17'h1D8A8
`define DPL_IVL_RST      6'h01
// filter shift for the holdover post-filter
`define DPL_FILT_SH      4
// ----------------------------------------
// timing
// ----------------------------------------
`define DPL_CLK_NS       40
`define DPL_SEC_NS       1000000000
`define DPL_SEC_CYC      (`DPL_SEC_NS / `DPL_CLK_NS)
// axi answers
`define DPL_RESP_OK      2'h0
`define DPL_RESP_ERR     2'h2
`endif

/* hdl/dpl_state_align.sv */
// dpll channel state control, holdover storage and frame/sync alignment
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "dpl_regs.svh"
module dpl_state_align #(
  parameter int SEC_CYC = `DPL_SEC_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             anyQual,
  input  wire logic             selQual,
  input  wire logic             lockDet,
  input  wire logic             swDisq,
  input  wire logic             swRevert,
  input  wire logic             swForced,
  input  wire dpl_pkg::dpl_off_t freqOffset,
  input  wire logic             framePin,
  input  wire logic             assocClkPin,
  output dpl_pkg::dpl_state_e   dpllState,
  output logic                  freeRun,
  output logic                  trackEn,
  output logic                  holdAct,
  output logic [3:0]            bwCode,
  output logic                  intLoad,
  output dpl_pkg::dpl_off_t     intVal,
  output logic                  alignPulse
);
  import dpl_pkg::*;

  dpl_state_s r_r;
  dpl_state_s r_nxt;
  logic       refSwitch;
  logic       allGone;

  // byte-lane merge for axi writes
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // ----------------------------------------
  // reference events
  // ----------------------------------------
  assign refSwitch = swDisq | swRevert | swForced;
  assign allGone   = !selQual && !anyQual;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic        tick;
    logic        refresh;
    logic [31:0] v;
    logic [2:0]  md;
    dpl_off_t    dlt;
    logic        frmEdge;
    logic        clkRise;
    tick    = 1'b0;
    refresh = 1'b0;
    v       = 32'h0000_0000;
    md      = r_r.ctrl[`DPL_CTRL_MODE];
    dlt     = 24'h00_0000;
    frmEdge = 1'b0;
    clkRise = 1'b0;
    r_nxt   = r_r;
    // axi write: address and data taken in either order
    if (s_axi_awvalid && r_r.awRdy) begin
      r_nxt.awHave = 1'b1;
      r_nxt.awa    = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_r.wRdy) begin
      r_nxt.wHave = 1'b1;
      r_nxt.wd    = s_axi_wdata;
      r_nxt.ws    = s_axi_wstrb;
    end
    if (r_r.bVal && s_axi_bready) begin
      r_nxt.bVal = 1'b0;
    end
    if (r_r.awHave && r_r.wHave && !r_r.bVal) begin
      r_nxt.awHave = 1'b0;
      r_nxt.wHave  = 1'b0;
      r_nxt.bVal   = 1'b1;
      r_nxt.bResp  = `DPL_RESP_OK;
      case ({r_r.awa[7:2], 2'b00})
        `DPL_CTRL_OFS: r_nxt.ctrl = mrg(r_r.ctrl, r_r.wd, r_r.ws) & 32'h0000_007F;
        `DPL_BWREQ_OFS: begin
          v = mrg({15'h0000, r_r.bwReq}, r_r.wd, r_r.ws);
          r_nxt.bwReq = v[16:0];
        end
        `DPL_IVL_OFS: begin
          v = mrg({26'h000_0000, r_r.ivl}, r_r.wd, r_r.ws);
          r_nxt.ivl = v[5:0];
        end
        `DPL_MANHOLD_OFS: begin
          v = mrg({8'h00, r_r.manHold}, r_r.wd, r_r.ws);
          r_nxt.manHold = v[23:0];
        end
        `DPL_STATUS_OFS, `DPL_HOLDVAL_OFS: r_nxt.bResp = `DPL_RESP_OK;
        default: r_nxt.bResp = `DPL_RESP_ERR;
      endcase
    end
    r_nxt.awRdy = !r_nxt.awHave && !r_nxt.bVal;
    r_nxt.wRdy  = !r_nxt.wHave && !r_nxt.bVal;
    // axi read: one outstanding, answered the cycle after the address
    if (r_r.rVal && s_axi_rready) begin
      r_nxt.rVal = 1'b0;
    end
    if (s_axi_arvalid && r_r.arRdy) begin
      r_nxt.rVal  = 1'b1;
      r_nxt.rResp = `DPL_RESP_OK;
      case ({s_axi_araddr[7:2], 2'b00})
        `DPL_CTRL_OFS:    r_nxt.rData = r_r.ctrl;
        `DPL_BWREQ_OFS:   r_nxt.rData = {15'h0000, r_r.bwReq};
        `DPL_IVL_OFS:     r_nxt.rData = {26'h000_0000, r_r.ivl};
        `DPL_MANHOLD_OFS: r_nxt.rData = {8'h00, r_r.manHold};
        `DPL_STATUS_OFS:  r_nxt.rData = {24'h00_0000, r_r.bwCode, 1'b0, r_r.st};
        `DPL_HOLDVAL_OFS: r_nxt.rData = {8'h00, r_r.hold1};
        default: begin
          r_nxt.rData = 32'h0000_0000;
          r_nxt.rResp = `DPL_RESP_ERR;
        end
      endcase
    end
    r_nxt.arRdy = !r_nxt.rVal;
    // operating mode and automatic machine; loss of all references wins
    case (md)
      `DPL_MODE_FLOCK: r_nxt.st = LOCKED;
      `DPL_MODE_FFREE: r_nxt.st = FREERUN;
      `DPL_MODE_FHOLD, `DPL_MODE_MHOLD: r_nxt.st = HOLDOVER;
      default: begin
        case (r_r.st)
          FREERUN: if (anyQual && selQual) r_nxt.st = LOCK_ACQ;
          LOCK_ACQ: begin
            if (allGone) r_nxt.st = FREERUN;
            else if (lockDet) r_nxt.st = LOCKED;
            else r_nxt.st = LOCK_ACQ;
          end
          LOCKED: begin
            if (allGone) r_nxt.st = HOLDOVER;
            else if (refSwitch) r_nxt.st = LOCK_REC;
          end
          HOLDOVER: if (anyQual) r_nxt.st = LOCK_REC;
          LOCK_REC: begin
            if (allGone) r_nxt.st = HOLDOVER;
            else if (lockDet) r_nxt.st = LOCKED;
            else r_nxt.st = LOCK_REC;
          end
          default: r_nxt.st = FREERUN;
        endcase
      end
    endcase
    // loop steering outputs follow the new state; the bandwidth code follows the request register
    r_nxt.freeRun = r_nxt.st == FREERUN;
    r_nxt.trackEn = r_nxt.st == LOCKED || r_nxt.st == LOCK_ACQ
                    || r_nxt.st == LOCK_REC;
    r_nxt.holdAct = r_nxt.st == HOLDOVER;
    r_nxt.bwCode  = dpl_bw_quant(r_r.bwReq);
    // one-second timebase; a long count, so shortened by parameter in sims
    if (r_r.secCnt >= 32'(SEC_CYC - 1)) begin
      r_nxt.secCnt = 32'h0000_0000;
      tick         = 1'b1;
    end else begin
      r_nxt.secCnt = r_r.secCnt + 32'h0000_0001;
    end
    if (tick) begin
      r_nxt.ivlCnt = (r_r.ivlCnt >= r_r.ivl) ? 6'h00 : r_r.ivlCnt + 6'h01;
    end
    refresh = (r_r.ivl == 6'h00) || (tick && r_r.ivlCnt >= r_r.ivl);
    // post-filter and the two holdover stores update only while locked; free-run clears the filter
    if (r_r.st == LOCKED) begin
      dlt          = freqOffset - r_r.filt;
      r_nxt.filt   = r_r.filt + dpl_off_t'($signed(dlt) >>> `DPL_FILT_SH);
      r_nxt.lastOff = freqOffset;
      if (refresh) begin
        r_nxt.hold0 = r_r.filt;
        r_nxt.hold1 = r_r.hold0;
      end
    end else if (r_r.st == FREERUN) begin
      r_nxt.filt = 24'h00_0000;
    end
    // integrator load on holdover entry
    r_nxt.intLoad = r_nxt.st == HOLDOVER && r_r.st != HOLDOVER;
    if (r_nxt.intLoad) begin
      if (md == `DPL_MODE_MHOLD) r_nxt.intVal = r_r.manHold;
      else if (r_r.ctrl[`DPL_CTRL_ADV]) r_nxt.intVal = r_r.hold1;
      else r_nxt.intVal = r_r.lastOff;
    end
    // frame and sync alignment on synchronised pins
    r_nxt.frmSy   = {r_r.frmSy[0], framePin};
    r_nxt.clkSy   = {r_r.clkSy[0], assocClkPin};
    r_nxt.frmPrev = r_r.frmSy[1];
    r_nxt.clkPrev = r_r.clkSy[1];
    frmEdge = r_r.ctrl[`DPL_CTRL_FALL] ? (r_r.frmPrev && !r_r.frmSy[1])
                                       : (!r_r.frmPrev && r_r.frmSy[1]);
    clkRise = !r_r.clkPrev && r_r.clkSy[1];
    r_nxt.alignPulse = 1'b0;
    if (!r_r.ctrl[`DPL_CTRL_ALIGN]) begin
      r_nxt.armed = 1'b0;
    end else if (r_r.ctrl[`DPL_CTRL_SYNC]) begin
      r_nxt.armed      = 1'b0;
      r_nxt.alignPulse = frmEdge;
    end else if (frmEdge) begin
      r_nxt.armed = 1'b1;
    end else if (r_r.armed && clkRise) begin
      r_nxt.armed      = 1'b0;
      r_nxt.alignPulse = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      r_r        <= '0;
      r_r.st     <= FREERUN;
      r_r.ctrl   <= `DPL_CTRL_RST;
      r_r.bwReq  <= `DPL_BWREQ_RST;
      r_r.ivl    <= `DPL_IVL_RST;
      r_r.freeRun <= 1'b1;
      r_r.bwCode <= 4'h9;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  // outputs come straight from the state register
  assign s_axi_awready = r_r.awRdy;
  assign s_axi_wready  = r_r.wRdy;
  assign s_axi_bvalid  = r_r.bVal;
  assign s_axi_bresp   = r_r.bResp;
  assign s_axi_arready = r_r.arRdy;
  assign s_axi_rvalid  = r_r.rVal;
  assign s_axi_rdata   = r_r.rData;
  assign s_axi_rresp   = r_r.rResp;
  assign dpllState     = r_r.st;
  assign freeRun       = r_r.freeRun;
  assign trackEn       = r_r.trackEn;
  assign holdAct       = r_r.holdAct;
  assign bwCode        = r_r.bwCode;
  assign intLoad       = r_r.intLoad;
  assign intVal        = r_r.intVal;
  assign alignPulse    = r_r.alignPulse;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic autoM;
  assign autoM = r_r.ctrl[`DPL_CTRL_MODE] == `DPL_MODE_AUTO;

  property p_rst_free;
    disable iff (1'b0) reset |=> dpllState == FREERUN && freeRun;
  endproperty
  a_rst_free: assert property (p_rst_free) else $error("not free-run after reset");

  property p_acq;
    ce && autoM && r_r.st == FREERUN && anyQual && selQual |=> dpllState == LOCK_ACQ;
  endproperty
  a_acq: assert property (p_acq) else $error("no lock acquire");

  property p_acq_lost;
    ce && autoM && r_r.st == LOCK_ACQ && !anyQual && !selQual |=> dpllState == FREERUN;
  endproperty
  a_acq_lost: assert property (p_acq_lost) else $error("acquire did not fall back");

  property p_lock;
    ce && autoM && (r_r.st == LOCK_ACQ || r_r.st == LOCK_REC) && (anyQual || selQual)
      && lockDet |=> dpllState == LOCKED;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not entered");

  property p_hold;
    ce && autoM && (r_r.st == LOCKED || r_r.st == LOCK_REC) && !anyQual && !selQual
      |=> dpllState == HOLDOVER && intLoad;
  endproperty
  a_hold: assert property (p_hold) else $error("holdover not entered");

  property p_rec;
    ce && autoM && r_r.st == LOCKED && (anyQual || selQual) && refSwitch
      |=> dpllState == LOCK_REC [*1] ##1 dpllState != FREERUN;
  endproperty
  a_rec: assert property (p_rec) else $error("switch did not enter recover");

  property p_fhold;
    ce && r_r.ctrl[`DPL_CTRL_MODE] == `DPL_MODE_FHOLD |=> holdAct && !trackEn;
  endproperty
  a_fhold: assert property (p_fhold) else $error("forced holdover left");

  property p_adv_load;
    $rose(r_r.intLoad) && autoM && r_r.ctrl[`DPL_CTRL_ADV] |-> intVal == $past(r_r.hold1);
  endproperty
  a_adv_load: assert property (p_adv_load) else $error("wrong holdover load");

  property p_sync;
    ce && r_r.ctrl[`DPL_CTRL_ALIGN] && r_r.ctrl[`DPL_CTRL_SYNC]
      && !r_r.ctrl[`DPL_CTRL_FALL] && !r_r.frmPrev && r_r.frmSy[1] |=> alignPulse;
  endproperty
  a_sync: assert property (p_sync) else $error("sync edge missed");

  property p_free_out;
    dpllState == FREERUN |-> freeRun && !trackEn && !holdAct;
  endproperty
  a_free_out: assert property (p_free_out) else $error("free-run tracking");
endmodule // dpl_state_align
